// ### dv/sac_analog_sources.sv
// Analog sources, hold capacitor, comparator and free-running RC oscillator
`timescale 1ns/1ps
module sac_analog_sources #(
    parameter int RC_HALF_NS = 100
) (
    input wire logic [39:0] levels,
    input wire logic [3:0] channelEnable,
    input wire logic sampleEnable,
    input wire logic [9:0] trialCode,
    output logic compareHigh,
    output logic rcClockPin
);
    logic [9:0] held = 10'h000;
    initial rcClockPin = 1'b0;
    always #(RC_HALF_NS) rcClockPin = ~rcClockPin;
    // Hold capacitor tracks the routed input only while acquiring
    always @*
    begin
        for (int i = 0; i < 4; i++)
            if (sampleEnable && channelEnable[i])
                held = levels[i*10 +: 10];
    end
    assign compareHigh = (held >= trialCode);
endmodule : sac_analog_sources

// ### dv/sac_top_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sac_top_bench;
    localparam int RC_CLKS = 20;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hready, hreadyout, hresp, compareHigh, rcClockPin, irq;
    logic referenceExternal, converterEnable, sampleEnable;
    logic [3:0] channelEnable, digitalInputDisable, pinHighZ;
    logic [9:0] trialCode;
    // Inputs 0 and 1 sit at full scale: the /2 and /4 runs are too fast to resolve
    logic [39:0] levels = {10'h2A5, 10'h13C, 10'h3FF, 10'h3FF};
    int failures = 0;
    int numChecks = 0;
    always #5 clock = ~clock;
    assign hready = hreadyout;
    sac_top u_dut (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .compareHigh, .rcClockPin, .channelEnable,
        .referenceExternal, .converterEnable, .sampleEnable, .trialCode,
        .digitalInputDisable, .pinHighZ, .irq);
    sac_analog_sources u_src (.levels, .channelEnable, .sampleEnable, .trialCode,
        .compareHigh, .rcClockPin);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        numChecks++;
        if (seen !== want)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        check(q, want);
    endtask : rdChk
    task automatic countWhile(input logic lvl, output int n);
        n = 0;
        @(posedge clock);
        while (sampleEnable === lvl && n < 2000)
        begin
            n++;
            @(posedge clock);
        end
    endtask : countWhile
    task automatic startConv(input logic [2:0] dv, input int ch, input logic [7:0] cfg,
        input logic ien);
        int w;
        wr(8'h04, {25'h0, dv, 4'hF});
        wr(8'h8C, {25'h0, ien, 6'h00});
        wr(8'h00, {24'h0, cfg | 8'h01 | 8'(ch << 2)});
        wr(8'h00, {24'h0, cfg | 8'h03 | 8'(ch << 2)});
        countWhile(1'b1, w);
        check(w >= 4, dv[1:0] == 2'b11);
        check(channelEnable, 4'h1 << ch);
        check(referenceExternal, cfg[6]);
    endtask : startConv
    task automatic resultChk(input logic [9:0] v, input logic just);
        rdChk(8'h10, just ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
        rdChk(8'h14, just ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00});
    endtask : resultChk
    task automatic checkResetValues();
        rdChk(8'h00, 32'h00000000);
        rdChk(8'h04, 32'h0000000F);
        rdChk(8'h18, 32'h0000000F);
        rdChk(8'h0C, 32'h00000000);
        rdChk(8'h8C, 32'h00000000);
        rdChk(8'h40, 32'h00000000);
        check(pinHighZ, 4'hF);
        wr(8'h18, 32'h00000005);
        rdChk(8'h18, 32'h00000005);
        repeat (2) @(posedge clock);
        check(pinHighZ, 4'h5);
    endtask : checkResetValues
    task automatic runConversions();
        logic [2:0] divs [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
        int per [7] = '{2, 4, 8, 16, 32, 64, RC_CLKS};
        int n;
        // The RC run stands for a conversion done while the core sleeps
        for (int i = 0; i < 7; i++)
        begin
            startConv(divs[i], i % 4, {i[0], i[1], 6'h00}, i[0]);
            countWhile(1'b0, n);
            if (i == 6)
                check(n >= 10 * RC_CLKS && n <= 12 * RC_CLKS + 8, 1'b1);
            else
                check(n >= 11 * per[i] - 2 && n <= 11 * per[i] + 4, 1'b1);
            repeat (3) @(posedge clock);
            check(irq, i[0]);
            rdChk(8'h00, {24'h0, i[0], i[1], 2'h0, 2'(i % 4), 2'h1});
            rdChk(8'h0C, 32'h00000040);
            rdChk(8'h0C, 32'h00000000);
            repeat (3) @(posedge clock);
            check(irq, 1'b0);
            resultChk(levels[(i % 4) * 10 +: 10], i[0]);
        end
    endtask : runConversions
    task automatic checkAbort();
        int n;
        startConv(3'h6, 3, 8'h80, 1'b1);
        countWhile(1'b0, n);
        startConv(3'h6, 1, 8'h80, 1'b1);
        repeat (100) @(posedge clock);
        wr(8'h00, 32'h00000085);
        countWhile(1'b0, n);
        check(n >= 2 * 64 && n <= 2 * 64 + 8, 1'b1);
        rdChk(8'h0C, 32'h00000040);
        resultChk(levels[39:30], 1'b1);
        wr(8'h00, 32'h00000000);
        repeat (3) @(posedge clock);
        check(channelEnable, 4'h0);
        check(converterEnable, 1'b0);
    endtask : checkAbort
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        checkResetValues();
        runConversions();
        checkAbort();
        complete_run();
    end
endmodule : sac_top_bench
bind sac_top sac_top_sva #(.RESULT_W(RESULT_W)) u_sva (.clock, .resetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .channelEnable,
    .referenceExternal, .converterEnable, .sampleEnable, .trialCode, .digitalInputDisable);

// ### dv/sac_top_sva.sv
// Port checker for the converter control block
`timescale 1ns/1ps
module sac_top_sva #(
    parameter int RESULT_W = 10
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [3:0] channelEnable,
    input wire logic referenceExternal,
    input wire logic converterEnable,
    input wire logic sampleEnable,
    input wire logic [RESULT_W-1:0] trialCode,
    input wire logic [3:0] digitalInputDisable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    logic wrPend;
    logic wrDone;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    // Keeps the address of the last accepted transfer, read or write, and the data of the last write
    always_ff @(posedge clock)
    begin
        wrPend <= resetn && hsel && htrans[1] && hwrite && hready;
        wrDone <= wrPend;
        if (hsel && htrans[1] && hready)
            wrAddr <= haddr[7:0];
        if (wrPend)
            wrData <= hwdata;
    end
    sequence convStart;
        converterEnable && $fell(sampleEnable);
    endsequence
    sequence convBody;
        !sampleEnable [*8] ##[1:800] sampleEnable;
    endsequence
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    ready_after_reset_a: assert property ($past(resetn) |-> hreadyout)
        else $error("wait state inserted");
    channel_onehot_a: assert property ($onehot0(channelEnable))
        else $error("more than one input routed");
    power_off_mux_a: assert property (
        $fell(converterEnable) |-> ##[0:1] channelEnable == 4'h0)
        else $error("input still routed when off");
    idle_trial_zero_a: assert property (
        sampleEnable && $past(sampleEnable) |-> trialCode == '0)
        else $error("trial code outside conversion");
    conv_length_a: assert property (convStart |-> convBody)
        else $error("conversion length out of bounds");
    ref_follow_a: assert property (
        wrDone && wrAddr == 8'h00 |-> ##[1:2] referenceExternal == wrData[6])
        else $error("reference select not applied");
    pins_follow_a: assert property (
        wrDone && wrAddr == 8'h04 |-> ##[1:2] digitalInputDisable == wrData[3:0])
        else $error("analog pin select not applied");
endmodule : sac_top_sva

// ### verilog/sac_bit_clock.sv
// Bit period tick generator: oscillator divider or synchronised dedicated RC clock
`timescale 1ns/1ps
module sac_bit_clock (
    input wire logic clock,
    input wire logic resetn,
    input wire logic run,
    input wire logic [2:0] divSelect,
    input wire logic rcClockPin,
    output logic bitTick
);
    logic [5:0] divCount;
    logic [2:0] rcSync;
    logic rcLevel;
    logic [2:0] exponent;
    logic [5:0] divLast;
    logic useRc;
    logic divDone;
    logic rcAgree;
    logic rcRise;

    // 000:/2 100:/4 001:/8 101:/16 010:/32 110:/64, x11 dedicated RC
    assign useRc = (divSelect & sac_pkg::DIV_RC_MASK) == sac_pkg::DIV_RC_MASK;
    assign exponent = {divSelect[1:0], divSelect[2]} + 3'h1;
    assign divLast = 6'((7'h01 << exponent) - 7'h01);
    assign divDone = divCount == divLast;
    assign rcAgree = rcSync[1] == rcSync[2];
    assign rcRise = rcAgree && rcSync[1] && !rcLevel;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            rcSync <= 3'h0;
            rcLevel <= 1'b0;
        end
        else
        begin
            rcSync <= {rcSync[1:0], rcClockPin};
            if (rcAgree)
                rcLevel <= rcSync[1];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn || !run || divDone)
            divCount <= 6'h00;
        else
            divCount <= divCount + 6'h01;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            bitTick <= 1'b0;
        else
            bitTick <= run && (useRc ? rcRise : divDone); // [RL5]
    end
endmodule : sac_bit_clock

// ### verilog/sac_pkg.sv
// Package of register map, field layout, reset values and timing counts for the converter
package sac_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_ANALOG_SELECT = 8'h04;
    localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_RESULT_HIGH = 8'h10;
    localparam logic [7:0] OFF_RESULT_LOW = 8'h14;
    localparam logic [7:0] OFF_PIN_DIRECTION = 8'h18;
    localparam logic [7:0] OFF_IRQ_ENABLES = 8'h8C;

    // Control register fields
    localparam int CTL_POWER = 0;
    localparam int CTL_REQUEST = 1;
    localparam int CTL_CHANNEL_LO = 2;
    localparam int CTL_REFERENCE = 6;
    localparam int CTL_JUSTIFY = 7;
    // Analog select register fields
    localparam int ASEL_PINS_LO = 0;
    localparam int ASEL_DIV_LO = 4;
    // Flag and enable bit of the conversion event
    localparam int IRQ_DONE = 6;

    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [3:0] RST_ANALOG_PINS = 4'hF;
    localparam logic [2:0] RST_DIVIDER = 3'h0;
    localparam logic [3:0] RST_PIN_DIRECTION = 4'hF;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;

    localparam int RESULT_W = 10;
    localparam int CONVERT_PERIODS = 11;
    localparam int ABORT_PERIODS = 2;
    // One instruction cycle is four oscillator clocks
    localparam int INSTR_CLOCKS = 4;
    localparam logic [2:0] DIV_RC_MASK = 3'h3;

    typedef enum logic [2:0] {SAC_IDLE, SAC_START_DELAY, SAC_CONVERT, SAC_ABORT_WAIT} sac_state_e;
endpackage : sac_pkg

// ### verilog/sac_top.sv
// Successive-approximation converter control with AHB-Lite register slave
// Notes on behaviour
// RL1: Convert chosen input by successive approximation into a 10-bit result.
// RL2: Exactly one of four inputs drives the sample-and-hold, per channel field.
// RL3: Reference select 1 uses external reference pin, 0 uses supply.
// RL4: A full conversion lasts exactly 11 bit periods; with the RC clock the first period is a partial one, giving 10 to 11.
// RL5: Divider field picks oscillator /2,/4,/8,/16,/32,/64 or the RC clock.
// RL6: Software must pick a bit period of at least 1.6 microseconds.
// RL7: Writing 1 to the request bit starts a conversion.
// RL8: On completion clear request, set done flag, interrupt if enabled.
// RL9: Clearing request mid-conversion aborts; result pair keeps previous value.
// RL10: After abort wait 2 bit periods, then acquire the selected channel.
// RL11: Software must not set request in the same write that powers on.
// RL12: Analog pin bit disables digital input; direction bit tri-states driver.
// RL13: Above 1 MHz oscillator, use RC clock only for conversions in sleep.
// RL14: Channel 00 to input 0 through 11 to input 3.
// RL15: Justify 1 right-justifies the result pair, 0 left-justifies it.
// RL16: Power 1 runs the converter, 0 shuts it off.
// RL17: With RC clock, wait one instruction cycle after request before converting.
// RL18: Done flag stays set until software clears it, not by a new start.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module sac_top #(
    parameter int RESULT_W = sac_pkg::RESULT_W
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic compareHigh,
    input wire logic rcClockPin,
    output logic [3:0] channelEnable,
    output logic referenceExternal,
    output logic converterEnable,
    output logic sampleEnable,
    output logic [RESULT_W-1:0] trialCode,
    output logic [3:0] digitalInputDisable,
    output logic [3:0] pinHighZ,
    output logic irq
);
    logic [7:0] control;
    logic [3:0] analogPins;
    logic [2:0] divSelect;
    logic [3:0] pinDirection;
    logic [7:0] irqFlags;
    logic [7:0] irqEnables;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] probe;
    logic [3:0] periodCount;
    logic [2:0] delayCount;
    logic [2:0] cmpSync;
    logic cmpLevel;
    sac_pkg::sac_state_e state;
    sac_pkg::sac_state_e next_state;
    logic wrPending;
    logic [7:0] wrAddr;

    logic bitTick;
    logic addrPhase;
    logic rdAccept;
    logic wrAccept;
    logic [7:0] rdAddr;
    logic [31:0] rdData;
    logic [7:0] resultHigh;
    logic [7:0] resultLow;
    logic wrControl;
    logic wrAnalog;
    logic wrDirection;
    logic wrEnables;
    logic rdFlags;
    logic powerOn;
    logic request;
    logic useRc;
    logic clockRun;
    logic startNow;
    logic abortNow;
    logic lastPeriod;
    logic doneEvent;
    logic keepBit;
    logic [RESULT_W-1:0] decided;
    logic cmpAgree;
    logic stateHolds;
    logic [3:0] abortLast;

    // Bus decode: zero-wait slave, every transfer answered OKAY
    assign addrPhase = hsel && htrans[1] && hready;
    assign rdAccept = addrPhase && !hwrite;
    assign wrAccept = addrPhase && hwrite;
    assign rdAddr = {haddr[7:2], 2'b00};
    assign wrControl = wrPending && wrAddr == sac_pkg::OFF_CONTROL;
    assign wrAnalog = wrPending && wrAddr == sac_pkg::OFF_ANALOG_SELECT;
    assign wrDirection = wrPending && wrAddr == sac_pkg::OFF_PIN_DIRECTION;
    assign wrEnables = wrPending && wrAddr == sac_pkg::OFF_IRQ_ENABLES;
    assign rdFlags = rdAccept && rdAddr == sac_pkg::OFF_IRQ_FLAGS;

    assign powerOn = control[sac_pkg::CTL_POWER];
    assign request = control[sac_pkg::CTL_REQUEST];
    assign useRc = (divSelect & sac_pkg::DIV_RC_MASK) == sac_pkg::DIV_RC_MASK;

    // Result pair view depends on the justify bit
    assign resultHigh = control[sac_pkg::CTL_JUSTIFY] ? {6'h00, result[9:8]} : result[9:2];
    assign resultLow = control[sac_pkg::CTL_JUSTIFY] ? result[7:0] : {result[1:0], 6'h00}; // [RL15]

    always_comb
    begin
        rdData = 32'h0000_0000;
        case (rdAddr)
            sac_pkg::OFF_CONTROL: rdData = {24'h000000, control};
            sac_pkg::OFF_ANALOG_SELECT: rdData = {25'h0000000, divSelect, analogPins};
            sac_pkg::OFF_IRQ_FLAGS: rdData = {24'h000000, irqFlags};
            sac_pkg::OFF_RESULT_HIGH: rdData = {24'h000000, resultHigh};
            sac_pkg::OFF_RESULT_LOW: rdData = {24'h000000, resultLow};
            sac_pkg::OFF_PIN_DIRECTION: rdData = {28'h0000000, pinDirection};
            sac_pkg::OFF_IRQ_ENABLES: rdData = {24'h000000, irqEnables};
            default: rdData = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            wrPending <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            wrPending <= wrAccept;
            wrAddr <= rdAddr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rdAccept)
                hrdata <= rdData;
        end
    end

    // Bit period source; it drops for the cycle of each state change so the divider
    // restarts and the abort wait lasts whole bit periods
    assign stateHolds = state == next_state;
    assign clockRun = stateHolds &&
        (state == sac_pkg::SAC_CONVERT || state == sac_pkg::SAC_ABORT_WAIT); // [RL10]

    sac_bit_clock u_bit_clock (
        .clock(clock),
        .resetn(resetn),
        .run(clockRun),
        .divSelect(divSelect),
        .rcClockPin(rcClockPin),
        .bitTick(bitTick)
    );

    // Comparator level from the analog side, filtered through three flops
    // The filter costs about four clocks; bit periods of four clocks or fewer decide on stale levels
    assign cmpAgree = cmpSync[1] == cmpSync[2];

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            cmpSync <= 3'h0;
            cmpLevel <= 1'b0;
        end
        else
        begin
            cmpSync <= {cmpSync[1:0], compareHigh};
            if (cmpAgree)
                cmpLevel <= cmpSync[1];
        end
    end

    // Sequencer
    assign startNow = state == sac_pkg::SAC_IDLE && request && powerOn; // [RL7]
    assign abortNow = !request || !powerOn; // [RL9]
    assign lastPeriod = periodCount == 4'(sac_pkg::CONVERT_PERIODS - 1); // [RL4]
    // RC phase runs free, so one extra tick keeps the abort wait at two whole periods
    assign abortLast = useRc ? 4'(sac_pkg::ABORT_PERIODS) : 4'(sac_pkg::ABORT_PERIODS - 1);
    assign doneEvent = state == sac_pkg::SAC_CONVERT && bitTick && lastPeriod && !abortNow;
    assign keepBit = cmpLevel;
    // Trial bit stays when the input is at or above the trial level
    assign decided = keepBit ? trialCode : (trialCode & ~probe); // [RL1]

    always_comb
    begin
        next_state = state;
        case (state)
            sac_pkg::SAC_IDLE:
                if (startNow)
                    next_state = useRc ? sac_pkg::SAC_START_DELAY : sac_pkg::SAC_CONVERT;
            sac_pkg::SAC_START_DELAY:
                if (abortNow)
                    next_state = sac_pkg::SAC_IDLE;
                else if (delayCount == 3'(sac_pkg::INSTR_CLOCKS - 1))
                    next_state = sac_pkg::SAC_CONVERT; // [RL17]
            sac_pkg::SAC_CONVERT:
                if (abortNow)
                    next_state = sac_pkg::SAC_ABORT_WAIT; // [RL10]
                else if (bitTick && lastPeriod)
                    next_state = sac_pkg::SAC_IDLE;
            sac_pkg::SAC_ABORT_WAIT:
                if (bitTick && periodCount == abortLast)
                    next_state = sac_pkg::SAC_IDLE; // [RL10]
            default: next_state = sac_pkg::SAC_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            state <= sac_pkg::SAC_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn || state != next_state)
        begin
            periodCount <= 4'h0;
            delayCount <= 3'h0;
        end
        else
        begin
            if (bitTick)
                periodCount <= periodCount + 4'h1;
            if (state == sac_pkg::SAC_START_DELAY)
                delayCount <= delayCount + 3'h1;
        end
    end

    // First period holds the sample, the next ten resolve one bit each
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            trialCode <= '0;
            probe <= '0;
        end
        else if (state != sac_pkg::SAC_CONVERT)
        begin
            trialCode <= '0;
            probe <= '0;
        end
        else if (bitTick && periodCount == 4'h0)
        begin
            trialCode <= {1'b1, {(RESULT_W-1){1'b0}}};
            probe <= {1'b1, {(RESULT_W-1){1'b0}}};
        end
        else if (bitTick)
        begin
            trialCode <= decided | (probe >> 1); // [RL1]
            probe <= probe >> 1;
        end
    end

    // Result only loads on a complete conversion
    always_ff @(posedge clock)
    begin
        if (!resetn)
            result <= '0;
        else if (doneEvent)
            result <= decided; // [RL1] [RL9]
    end

    // Software registers; hardware clears the request bit on completion
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            control <= sac_pkg::RST_CONTROL;
            analogPins <= sac_pkg::RST_ANALOG_PINS;
            divSelect <= sac_pkg::RST_DIVIDER;
            pinDirection <= sac_pkg::RST_PIN_DIRECTION;
            irqEnables <= sac_pkg::RST_IRQ_ENABLES;
        end
        else
        begin
            if (wrControl)
                control <= hwdata[7:0] & 8'hCF;
            else if (doneEvent)
                control[sac_pkg::CTL_REQUEST] <= 1'b0; // [RL8]
            if (wrAnalog)
            begin
                analogPins <= hwdata[sac_pkg::ASEL_PINS_LO +: 4];
                divSelect <= hwdata[sac_pkg::ASEL_DIV_LO +: 3];
            end
            if (wrDirection)
                pinDirection <= hwdata[3:0];
            if (wrEnables)
                irqEnables <= hwdata[7:0];
        end
    end

    // Sticky flags: read clears, a new event in that cycle wins
    always_ff @(posedge clock)
    begin
        if (!resetn)
            irqFlags <= sac_pkg::RST_IRQ_FLAGS;
        else if (doneEvent)
            irqFlags[sac_pkg::IRQ_DONE] <= 1'b1; // [RL8] [RL18]
        else if (rdFlags)
            irqFlags <= 8'h00; // [RL18]
    end

    // Analog side controls, all registered
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            channelEnable <= 4'h0;
            referenceExternal <= 1'b0;
            converterEnable <= 1'b0;
            sampleEnable <= 1'b0;
            digitalInputDisable <= sac_pkg::RST_ANALOG_PINS;
            pinHighZ <= sac_pkg::RST_PIN_DIRECTION;
            irq <= 1'b0;
        end
        else
        begin
            channelEnable <= powerOn ? 4'(4'h1 << control[sac_pkg::CTL_CHANNEL_LO +: 2]) : 4'h0; // [RL2] [RL14]
            referenceExternal <= control[sac_pkg::CTL_REFERENCE]; // [RL3]
            converterEnable <= powerOn; // [RL16]
            sampleEnable <= powerOn && (next_state == sac_pkg::SAC_IDLE ||
                next_state == sac_pkg::SAC_START_DELAY); // [RL10]
            digitalInputDisable <= analogPins; // [RL12]
            pinHighZ <= pinDirection; // [RL12]
            irq <= |(irqFlags & irqEnables); // [RL8]
        end
    end
endmodule : sac_top
